// ---- att_calib.sv ----
// Ambient baseline, extreme tracking, span calibration and trip levels for all stages.
`timescale 1ns/10ps
module att_calib
   import att_pkg::*;
#(
   parameter int unsigned NSTAGE = ATT_NSTAGE
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire att_reg_req_s reg_req_i,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   // Converter samples and slow FIFO ambient results
   input wire att_smp_s cdc_smp_i,
   input wire att_smp_s amb_smp_i
);

   // ==================================================================
   // Storage
   // ==================================================================
   logic [15:0] hspan_q [NSTAGE];
   logic [15:0] lspan_q [NSTAGE];
   logic [15:0] hlim_q [NSTAGE];
   logic [15:0] llim_q [NSTAGE];
   logic [15:0] base_q [NSTAGE];
   logic [15:0] amax_q [NSTAGE];
   logic [15:0] amin_q [NSTAGE];
   logic [15:0] utrip_q [NSTAGE];
   logic [15:0] ltrip_q [NSTAGE];
   logic [15:0] hcode_q;
   logic [15:0] lcode_q;
   logic [15:0] maxm_q;
   logic [15:0] minm_q;
   logic [3:0] sweep_q;
   logic [15:0] rd_data_q;
   logic rd_valid_q;

   // ==================================================================
   // Register address decode
   // ==================================================================
   wire [3:0] a_page = reg_req_i.addr[7:4];
   wire [3:0] a_idx = reg_req_i.addr[3:0];
   wire a_glob = (a_page == ATT_GLOBAL_PAGE);
   wire a_stage_ok = ({28'h0, a_page} < NSTAGE);
   wire wr_stage = reg_req_i.wr && a_stage_ok;
   wire wr_glob = reg_req_i.wr && a_glob;

   // ==================================================================
   // Sample path operands
   // ==================================================================
   wire [3:0] s = cdc_smp_i.stage;
   wire s_ok = cdc_smp_i.valid && ({28'h0, s} < NSTAGE);
   wire [3:0] si = s_ok ? s : 4'h0;
   wire [15:0] b = base_q[si];
   wire signed [17:0] hlim_s = $signed({2'b00, hlim_q[si]});
   wire signed [17:0] llim_s = $signed({{2{llim_q[si][15]}}, llim_q[si]});
   wire signed [17:0] diff = $signed({2'b00, cdc_smp_i.data}) - $signed({2'b00, b});

   // Sample offset from baseline held inside the clamp window.
   // response clamp
   wire signed [17:0] diff_c = (diff > hlim_s) ? hlim_s : ((diff < llim_s) ? llim_s : diff);

   // Sensitivity codes decoded into fractions of the tracked extreme.
   // level decode
   wire [10:0] hlvl = ATT_LVL_BASE + ATT_LVL_STEP * {7'h00, hcode_q[3:0]};
   wire [10:0] llvl = ATT_LVL_BASE + ATT_LVL_STEP * {7'h00, lcode_q[3:0]};

   // ==================================================================
   // High side tracking
   // ==================================================================
   wire signed [17:0] hi_ext = $signed({2'b00, amax_q[si]}) - $signed({2'b00, b});
   wire signed [22:0] hi_mprod = hi_ext * $signed({1'b0, maxm_q[3:0]});
   wire signed [17:0] hi_margin = hi_mprod[17 + ATT_MARGIN_SHIFT:ATT_MARGIN_SHIFT];
   wire hi_hit = s_ok && (diff_c > 18'sd0) && (diff_c > hi_margin);
   wire signed [18:0] hi_sum = hi_ext + diff_c;
   wire signed [17:0] hi_new = hi_sum[18:1];
   wire [15:0] amax_new = b + hi_new[15:0];
   wire signed [29:0] hi_tprod = hi_new * $signed({1'b0, hlvl});
   wire signed [17:0] hi_tgt = hi_tprod[17 + ATT_LVL_SHIFT:ATT_LVL_SHIFT];
   wire signed [17:0] hi_span_c = (hi_tgt > hlim_s) ? hlim_s :
                                  ((hi_tgt < 18'sd0) ? 18'sd0 : hi_tgt);

   // ==================================================================
   // Low side tracking
   // ==================================================================
   wire signed [17:0] lo_ext = $signed({2'b00, amin_q[si]}) - $signed({2'b00, b});
   wire signed [22:0] lo_mprod = lo_ext * $signed({1'b0, minm_q[3:0]});
   wire signed [17:0] lo_margin = lo_mprod[17 + ATT_MARGIN_SHIFT:ATT_MARGIN_SHIFT];
   wire lo_hit = s_ok && (diff_c < 18'sd0) && (diff_c < lo_margin);
   wire signed [18:0] lo_sum = lo_ext + diff_c;
   wire signed [17:0] lo_new = lo_sum[18:1];
   wire [15:0] amin_new = b + lo_new[15:0];
   wire signed [29:0] lo_tprod = lo_new * $signed({1'b0, llvl});
   wire signed [17:0] lo_tgt = lo_tprod[17 + ATT_LVL_SHIFT:ATT_LVL_SHIFT];
   wire signed [17:0] lo_span_c = (lo_tgt < llim_s) ? llim_s :
                                  ((lo_tgt > 18'sd0) ? 18'sd0 : lo_tgt);

   // ==================================================================
   // Host-loaded per-stage limits
   // ==================================================================
   // Clamp limits change only by host writes.
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < NSTAGE; i++)
         begin
            hlim_q[i] <= ATT_CFG_RST;
            llim_q[i] <= ATT_CFG_RST;
         end
      end
      else
      begin
         for (int i = 0; i < NSTAGE; i++)
         begin
            if (wr_stage && a_page == 4'(i) && a_idx == ATT_R_HIGH_LIM)
               hlim_q[i] <= reg_req_i.wdata;
            if (wr_stage && a_page == 4'(i) && a_idx == ATT_R_LOW_LIM)
               llim_q[i] <= reg_req_i.wdata;
         end
      end
   end

   // ==================================================================
   // Spans: calibration update wins over a host write in the same cycle
   // ==================================================================
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < NSTAGE; i++)
         begin
            hspan_q[i] <= ATT_DATA_RST;
            lspan_q[i] <= ATT_DATA_RST;
         end
      end
      else
      begin
         for (int i = 0; i < NSTAGE; i++)
         begin
            if (hi_hit && si == 4'(i))
               hspan_q[i] <= hi_span_c[15:0];
            else if (wr_stage && a_page == 4'(i) && a_idx == ATT_R_HIGH_SPAN)
               hspan_q[i] <= reg_req_i.wdata;
            if (lo_hit && si == 4'(i))
               lspan_q[i] <= lo_span_c[15:0];
            else if (wr_stage && a_page == 4'(i) && a_idx == ATT_R_LOW_SPAN)
               lspan_q[i] <= reg_req_i.wdata;
         end
      end
   end

   // ==================================================================
   // Baseline and tracked extremes
   // ==================================================================
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < NSTAGE; i++)
         begin
            base_q[i] <= ATT_DATA_RST;
            amax_q[i] <= ATT_DATA_RST;
            amin_q[i] <= ATT_DATA_RST;
         end
      end
      else
      begin
         for (int i = 0; i < NSTAGE; i++)
         begin
            if (amb_smp_i.valid && amb_smp_i.stage == 4'(i))
               base_q[i] <= amb_smp_i.data;
            if (hi_hit && si == 4'(i))
               amax_q[i] <= amax_new;
            if (lo_hit && si == 4'(i))
               amin_q[i] <= amin_new;
         end
      end
   end

   // ==================================================================
   // Global sensitivity and margin settings
   // ==================================================================
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hcode_q <= ATT_CFG_RST;
         lcode_q <= ATT_CFG_RST;
         maxm_q <= ATT_CFG_RST;
         minm_q <= ATT_CFG_RST;
      end
      else
      begin
         if (wr_glob && a_idx == ATT_G_HIGH_CODE)
            hcode_q <= reg_req_i.wdata;
         if (wr_glob && a_idx == ATT_G_LOW_CODE)
            lcode_q <= reg_req_i.wdata;
         if (wr_glob && a_idx == ATT_G_MAX_MARGIN)
            maxm_q <= reg_req_i.wdata;
         if (wr_glob && a_idx == ATT_G_MIN_MARGIN)
            minm_q <= reg_req_i.wdata;
      end
   end

   // ==================================================================
   // Trip levels: a sweep refreshes one stage per cycle
   // ==================================================================
   wire [15:0] utrip_new;
   wire [15:0] ltrip_new;
   wire [3:0] sweep_nx = ({28'h0, sweep_q} >= NSTAGE - 1) ? 4'h0 : sweep_q + 4'h1;

   att_trip_calc u_upper (
      .base_i(base_q[sweep_q]),
      .span_i(hspan_q[sweep_q]),
      .code_i(hcode_q[3:0]),
      .trip_o(utrip_new)
   );

   att_trip_calc u_lower (
      .base_i(base_q[sweep_q]),
      .span_i(lspan_q[sweep_q]),
      .code_i(lcode_q[3:0]),
      .trip_o(ltrip_new)
   );

   // Every stage is refreshed at least once each NSTAGE cycles.
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sweep_q <= 4'h0;
         for (int i = 0; i < NSTAGE; i++)
         begin
            utrip_q[i] <= ATT_DATA_RST;
            ltrip_q[i] <= ATT_DATA_RST;
         end
      end
      else
      begin
         sweep_q <= sweep_nx;
         utrip_q[sweep_q] <= utrip_new;
         ltrip_q[sweep_q] <= ltrip_new;
      end
   end

   // ==================================================================
   // Read data selection; unmapped addresses read as zero
   // ==================================================================
   wire [3:0] rp = a_stage_ok ? a_page : 4'h0;
   wire [15:0] rd_stage =
      (a_idx == ATT_R_HIGH_SPAN) ? hspan_q[rp] :
      (a_idx == ATT_R_LOW_SPAN) ? lspan_q[rp] :
      (a_idx == ATT_R_HIGH_LIM) ? hlim_q[rp] :
      (a_idx == ATT_R_LOW_LIM) ? llim_q[rp] :
      (a_idx == ATT_R_BASELINE) ? base_q[rp] :
      (a_idx == ATT_R_UPPER_TRIP) ? utrip_q[rp] :
      (a_idx == ATT_R_LOWER_TRIP) ? ltrip_q[rp] :
      (a_idx == ATT_R_AVG_MAX) ? amax_q[rp] :
      (a_idx == ATT_R_AVG_MIN) ? amin_q[rp] : 16'h0000;
   wire [15:0] rd_glob =
      (a_idx == ATT_G_HIGH_CODE) ? hcode_q :
      (a_idx == ATT_G_LOW_CODE) ? lcode_q :
      (a_idx == ATT_G_MAX_MARGIN) ? maxm_q :
      (a_idx == ATT_G_MIN_MARGIN) ? minm_q : 16'h0000;
   wire [15:0] rd_sel = a_stage_ok ? rd_stage : (a_glob ? rd_glob : 16'h0000);

   // Read answer is registered and valid for one cycle.
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rd_data_q <= 16'h0000;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_valid_q <= reg_req_i.rd;
         if (reg_req_i.rd)
            rd_data_q <= rd_sel;
      end
   end

   assign rd_data_o = rd_data_q;
   assign rd_valid_o = rd_valid_q;

endmodule

// ---- att_pkg.sv ----
// Shared constants, register map and carrier types of the adaptive trip level block.
package att_pkg;

   // ==================================================================
   // Widths
   // ==================================================================
   localparam int unsigned ATT_DW = 16;
   localparam int unsigned ATT_SW = 4;
   localparam int unsigned ATT_NSTAGE = 12;

   // ==================================================================
   // Per-stage register indexes (address bits [3:0])
   // ==================================================================
   localparam logic [3:0] ATT_R_HIGH_SPAN = 4'h0;
   localparam logic [3:0] ATT_R_LOW_SPAN = 4'h1;
   localparam logic [3:0] ATT_R_HIGH_LIM = 4'h2;
   localparam logic [3:0] ATT_R_LOW_LIM = 4'h3;
   localparam logic [3:0] ATT_R_BASELINE = 4'h4;
   localparam logic [3:0] ATT_R_UPPER_TRIP = 4'h5;
   localparam logic [3:0] ATT_R_LOWER_TRIP = 4'h6;
   localparam logic [3:0] ATT_R_AVG_MAX = 4'h7;
   localparam logic [3:0] ATT_R_AVG_MIN = 4'h8;

   // ==================================================================
   // Global registers (address bits [7:4] equal to the global page)
   // ==================================================================
   localparam logic [3:0] ATT_GLOBAL_PAGE = 4'hF;
   localparam logic [3:0] ATT_G_HIGH_CODE = 4'h0;
   localparam logic [3:0] ATT_G_LOW_CODE = 4'h1;
   localparam logic [3:0] ATT_G_MAX_MARGIN = 4'h2;
   localparam logic [3:0] ATT_G_MIN_MARGIN = 4'h3;

   // ==================================================================
   // Values after reset
   // ==================================================================
   localparam logic [15:0] ATT_DATA_RST = 16'h0000;
   localparam logic [15:0] ATT_CFG_RST = 16'h0000;

   // ==================================================================
   // Arithmetic constants
   // ==================================================================
   // Sensitivity level in 1/1024 units: 256 (25 %) plus 48 per code step up to 976.
   localparam logic [10:0] ATT_LVL_BASE = 11'h100;
   localparam logic [10:0] ATT_LVL_STEP = 11'h030;
   localparam int unsigned ATT_LVL_SHIFT = 10;
   // Peak-detect margin in 1/16 units of the extreme distance.
   localparam int unsigned ATT_MARGIN_SHIFT = 4;

   // ==================================================================
   // Carrier types
   // ==================================================================
   typedef struct packed {
      logic valid;
      logic [3:0] stage;
      logic [15:0] data;
   } att_smp_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } att_reg_req_s;

endpackage

// ---- att_trip_calc.sv ----
// Trip level arithmetic: baseline plus two quarter spans plus quarter span times code.
`timescale 1ns/10ps
module att_trip_calc
   import att_pkg::*;
(
   // Operands
   input wire logic [15:0] base_i,
   input wire logic [15:0] span_i,
   input wire logic [3:0] code_i,
   // Result
   output logic [15:0] trip_o
);

   logic [15:0] quarter;
   logic [19:0] prod;

   // Quarter span by arithmetic right shift so a negative low span stays negative.
   // truncating shift
   assign quarter = {{2{span_i[15]}}, span_i[15:2]};
   assign prod = {{4{quarter[15]}}, quarter} * {16'h0000, code_i};
   assign trip_o = base_i + quarter + quarter + prod[15:0];

endmodule

// ---- att_calib_sva.sv ----
// Port-level assertions for the adaptive trip level block.
`timescale 1ns/10ps
module att_calib_sva
   import att_pkg::*;
#(
   parameter int unsigned NSTAGE = ATT_NSTAGE
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire att_reg_req_s reg_req_i,
   input wire logic [15:0] rd_data_o,
   input wire logic rd_valid_o,
   // Samples
   input wire att_smp_s cdc_smp_i,
   input wire att_smp_s amb_smp_i
);
   // ==================================================================
   // Clocking and decoded request fields
   // ==================================================================
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Short names for the request fields, and the stage 0 ambient result strobe.
   wire logic rd_w = reg_req_i.rd;
   wire logic wr_w = reg_req_i.wr;
   wire logic [7:0] addr_w = reg_req_i.addr;
   wire logic amb0_w = amb_smp_i.valid && (amb_smp_i.stage == 4'h0);

   property p_rd_answer;
      rd_w |=> rd_valid_o;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered one cycle later");

   property p_rd_quiet;
      !rd_w |=> !rd_valid_o;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet)
      else $error("read valid without a read");

   property p_rd_hold;
      !rd_w |=> $stable(rd_data_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed without a read");

   property p_baseline;
      amb0_w ##1 !amb0_w ##1 (rd_w && addr_w == 8'h04 && !amb0_w) |=>
         rd_data_o == $past(amb_smp_i.data, 3);
   endproperty
   a_baseline: assert property (p_baseline)
      else $error("baseline does not follow ambient result");

   // host span write lands when no sample intervenes
   property p_span_rb;
      (wr_w && addr_w == 8'h10 && !cdc_smp_i.valid) ##1 (!wr_w && !cdc_smp_i.valid) ##1
         (rd_w && addr_w == 8'h10) |=> rd_data_o == $past(reg_req_i.wdata, 3);
   endproperty
   a_span_rb: assert property (p_span_rb)
      else $error("high span write not read back");

   property p_lim_rb;
      (wr_w && addr_w == 8'h23) ##1 !wr_w ##1 (rd_w && addr_w == 8'h23)
         |=> rd_data_o == $past(reg_req_i.wdata, 3);
   endproperty
   a_lim_rb: assert property (p_lim_rb)
      else $error("low clamp limit not read back");

   property p_code_rb;
      (wr_w && addr_w == 8'hF1) ##1 !wr_w ##1 (rd_w && addr_w == 8'hF1)
         |=> rd_data_o == $past(reg_req_i.wdata, 3);
   endproperty
   a_code_rb: assert property (p_code_rb)
      else $error("low code not read back");

   property p_unmapped;
      rd_w && addr_w[7:4] == 4'hE |=> rd_data_o == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
endmodule

bind att_calib att_calib_sva #(.NSTAGE(NSTAGE)) u_sva (
   .ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i),
   .reg_req_i(reg_req_i),
   .rd_data_o(rd_data_o),
   .rd_valid_o(rd_valid_o),
   .cdc_smp_i(cdc_smp_i),
   .amb_smp_i(amb_smp_i)
);

// ---- adaptive_touch_threshold_calib_tb_top.sv ----
// Self-checking bench for the adaptive trip level block.
`timescale 1ns/10ps
module adaptive_touch_threshold_calib_tb_top
   import att_pkg::*;
;
   // ==================================================================
   // Signals and counters
   // ==================================================================
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   att_reg_req_s req = '0;
   att_smp_s cdc = '0;
   att_smp_s amb = '0;
   logic [15:0] rd_data;
   logic rd_valid;
   logic [31:0] seed_q = 32'h4AAF4BCB;
   logic [15:0] b;
   logic [15:0] hs;
   logic [15:0] ls;
   int failures = 0;
   int n_compared = 0;

   att_calib #(.NSTAGE(ATT_NSTAGE)) dut (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .reg_req_i(req),
      .rd_data_o(rd_data),
      .rd_valid_o(rd_valid),
      .cdc_smp_i(cdc),
      .amb_smp_i(amb)
   );

   // The clock toggles every 25 ns, a period of 50 ns.
   initial
   begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   // ==================================================================
   // Expectation functions
   // ==================================================================
   // Next random word of the xorshift sequence.
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // Trip level: base plus two quarter spans plus quarter span times code.
   function automatic logic [15:0] exp_trip(input logic [15:0] base, span, input logic [3:0] c);
      logic [15:0] q;
      q = $unsigned($signed(span) >>> 2);
      return base + q + q + q * {12'h000, c};
   endfunction

   // Calibrated span: tracked extreme scaled by the code level, then clamped.
   function automatic logic [15:0] exp_span(input int nw, input logic [3:0] c, input int lo, hi);
      int v;
      v = (nw * (int'(ATT_LVL_BASE) + int'(ATT_LVL_STEP) * int'(c))) >>> ATT_LVL_SHIFT;
      if (v < lo) v = lo;
      if (v > hi) v = hi;
      return v[15:0];
   endfunction

   // ==================================================================
   // Port tasks
   // ==================================================================
   // Compare one value and count the outcome.
   task automatic chk(input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One-cycle write pulse.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge ref_clk_i);
      req.wr <= 1'b0;
   endtask

   // One-cycle read pulse; the answer is checked in the cycle after.
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge ref_clk_i);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge ref_clk_i);
      req.rd <= 1'b0;
      #1;
      chk({15'h0000, rd_valid}, 16'h0001);
      chk(rd_data, exp);
   endtask

   // One converter sample, or one ambient result when to_amb is set.
   task automatic push(input bit to_amb, input logic [3:0] s, input logic [15:0] d);
      @(posedge ref_clk_i);
      if (to_amb) amb <= '{1'b1, s, d};
      else cdc <= '{1'b1, s, d};
      @(posedge ref_clk_i);
      amb.valid <= 1'b0;
      cdc.valid <= 1'b0;
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // A hung run is cut short and counted as a failure.
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      failures++;
      end_of_test();
   end

   // ==================================================================
   // Main sequence
   // ==================================================================
   initial
   begin
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      // Reset values of one stage and the global page, then read-only places.
      for (int i = 0; i < 9; i++) rd_chk({4'h0, i[3:0]}, 16'h0000);
      for (int i = 0; i < 4; i++) rd_chk({4'hF, i[3:0]}, 16'h0000);
      wr(8'h04, 16'hBEEF);
      wr(8'h05, 16'h1234);
      rd_chk(8'h04, 16'h0000);
      rd_chk(8'h05, 16'h0000);
      rd_chk(8'hE5, 16'h0000);
      // Baseline from ambient result.
      push(1'b1, 4'h0, 16'h2A5C);
      rd_chk(8'h04, 16'h2A5C);
      // High side tracking on stage 1 with baseline zero.
      wr(8'h12, 16'h0400);
      wr(8'h10, 16'h0333);
      rd_chk(8'h10, 16'h0333);
      push(1'b0, 4'h1, 16'h0800);
      rd_chk(8'h17, 16'h0200);
      rd_chk(8'h10, exp_span(512, 4'h0, 0, 1024));
      wr(8'hF2, 16'h0008);
      push(1'b0, 4'h1, 16'h0100);
      rd_chk(8'h17, 16'h0200);
      push(1'b0, 4'h1, 16'h0300);
      rd_chk(8'h17, 16'h0280);
      rd_chk(8'h10, exp_span(640, 4'h0, 0, 1024));
      // Low side tracking on stage 2: samples below a raised baseline, negative clamp.
      push(1'b1, 4'h2, 16'h0400);
      wr(8'h23, 16'hFC00);
      rd_chk(8'h23, 16'hFC00);
      wr(8'hF1, 16'h000F);
      rd_chk(8'hF1, 16'h000F);
      push(1'b0, 4'h2, 16'h0200);
      rd_chk(8'h28, 16'h0100);
      rd_chk(8'h21, exp_span(-768, 4'hF, -1024, 0));
      // A margin of one half: a shallow dip is ignored, a deep one is tracked.
      wr(8'hF3, 16'h0008);
      push(1'b0, 4'h2, 16'h0300);
      rd_chk(8'h28, 16'h0100);
      push(1'b0, 4'h2, 16'h0000);
      rd_chk(8'h28, 16'h0080);
      ls = exp_span(-896, 4'hF, -1024, 0);
      rd_chk(8'h21, ls);
      repeat (ATT_NSTAGE + 1) @(posedge ref_clk_i);
      rd_chk(8'h26, exp_trip(16'h0400, ls, 4'hF));
      // Trip arithmetic on stage 3 for every code with random operands.
      for (int c = 0; c < 16; c++)
      begin
         seed_q = xs(seed_q);
         b = seed_q[15:0];
         hs = {2'b00, seed_q[29:16]};
         seed_q = xs(seed_q);
         ls = 16'h0000 - {2'b00, seed_q[13:0]};
         wr(8'hF0, {12'h000, c[3:0]});
         wr(8'hF1, {12'h000, 4'hF - c[3:0]});
         wr(8'h30, hs);
         wr(8'h31, ls);
         push(1'b1, 4'h3, b);
         repeat (ATT_NSTAGE + 1) @(posedge ref_clk_i);
         rd_chk(8'h35, exp_trip(b, hs, c[3:0]));
         rd_chk(8'h36, exp_trip(b, ls, 4'hF - c[3:0]));
      end
      end_of_test();
   end
endmodule
